// file: logic/sampling_routine_sequencer.sv
// Added by the designer: the Avalon-MM slave port and the register offsets.
`include "sampler_consts.svh"

module sampling_routine_sequencer
	import sampler_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        flow_pulse,
	input  wire logic        flow_enable,
	output logic             sample_event,
	output logic             advance_bottle,
	output logic             advance_set
);

	if (TICK_CYCLES < 2) begin : g_tick_check
		$error("TICK_CYCLES must be at least 2");
	end

	typedef struct packed {
		seq_state_t                  st;
		prog_t                       prog;
		prog_t                       run;
		logic [`SR_MAX-1:0][31:0]    sr_tab;
		logic [4:0]                  sr_sel;
		logic [4:0]                  sr_idx;
		logic [31:0]                 rtc;
		logic [31:0]                 tick_cnt;
		logic [31:0]                 dly;
		logic [31:0]                 pace_cnt;
		logic [31:0]                 bot_tmr;
		logic [31:0]                 set_tmr;
		logic [31:0]                 bot_smp;
		logic [31:0]                 set_smp;
		logic [31:0]                 next_evt;
		logic                        armed;
		logic                        missed;
		logic                        first_done;
		logic                        fl1;
		logic                        fl2;
		logic                        fl3;
		logic                        en1;
		logic                        en2;
		logic                        sample;
		logic                        adv_bot;
		logic                        adv_set;
		logic                        wait_q;
		logic [31:0]                 rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic reached(input logic [31:0] c, input logic [31:0] lim);
		return (c + 32'h0000_0001) >= lim;
	endfunction : reached

	function automatic logic [31:0] rd_mux(input state_t s, input logic [7:0] a);
		case (a)
			`OFS_CFG:       return {{(32-`CFG_W){1'b0}}, s.prog.cfg};
			`OFS_START_T:   return s.prog.start_time;
			`OFS_START_DLY: return s.prog.start_delay;
			`OFS_PACE:      return s.prog.pace;
			`OFS_BOT_TIME:  return s.prog.bot_time_iv;
			`OFS_SET_TIME:  return s.prog.set_time_iv;
			`OFS_BOT_CNT:   return s.prog.bot_cnt;
			`OFS_SET_CNT:   return s.prog.set_cnt;
			`OFS_FIRST_SW:  return s.prog.first_sw;
			`OFS_RTC:       return s.rtc;
			`OFS_STATUS:    return {20'h0_0000, s.sr_idx, s.armed, s.first_done,
			                        s.en2, 1'b0, s.st};
			`OFS_SR_SEL:    return {27'h000_0000, s.sr_sel};
			`OFS_SR_TIME:   return (s.sr_sel < 5'(`SR_MAX)) ? s.sr_tab[s.sr_sel] : 32'h0000_0000;
			`OFS_NEXT_EVT:  return s.next_evt;
			default:        return 32'h0000_0000;
		endcase
	endfunction : rd_mux

	logic tick, wr, start_cmd, abort_cmd, man_cmd, en, flow_edge;
	logic smp, go_run, sr_hit, bt, stt, active;
	logic [4:0] sr_eff;

	always_comb begin
		s_d          = s_q;
		s_d.sample   = 1'b0;
		s_d.adv_bot  = 1'b0;
		s_d.adv_set  = 1'b0;
		s_d.fl1      = flow_pulse;
		s_d.fl2      = s_q.fl1;
		s_d.fl3      = s_q.fl2;
		s_d.en1      = flow_enable;
		s_d.en2      = s_q.en1;
		en           = s_q.en2;
		flow_edge    = s_q.fl2 & ~s_q.fl3;
		smp          = 1'b0;
		go_run       = 1'b0;

		tick         = (s_q.tick_cnt == TICK_CYCLES - 1);
		s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;
		if (tick) s_d.rtc = s_q.rtc + 32'h0000_0001;

		// One wait cycle, then answer; read data stand while waitrequest is low
		s_d.wait_q = 1'b1;
		if ((read || write) && s_q.wait_q) begin
			s_d.wait_q = 1'b0;
			s_d.rdata  = rd_mux(s_q, address);
		end
		wr        = write && !s_q.wait_q;
		start_cmd = wr && address == `OFS_CTRL && writedata[`CTRL_START];
		abort_cmd = wr && address == `OFS_CTRL && writedata[`CTRL_ABORT];
		man_cmd   = wr && address == `OFS_CTRL && writedata[`CTRL_MANUAL];

		if (wr) begin
			case (address)
				`OFS_CFG:       s_d.prog.cfg         = cfg_t'(writedata[`CFG_W-1:0]);
				`OFS_START_T:   s_d.prog.start_time  = writedata;
				`OFS_START_DLY: s_d.prog.start_delay = writedata;
				`OFS_PACE:      s_d.prog.pace        = writedata;
				`OFS_BOT_TIME:  s_d.prog.bot_time_iv = writedata;
				`OFS_SET_TIME:  s_d.prog.set_time_iv = writedata;
				`OFS_BOT_CNT:   s_d.prog.bot_cnt     = writedata;
				`OFS_SET_CNT:   s_d.prog.set_cnt     = writedata;
				`OFS_FIRST_SW:  s_d.prog.first_sw    = writedata;
				`OFS_RTC:       s_d.rtc              = writedata;
				`OFS_SR_SEL:    s_d.sr_sel           = writedata[4:0];
				`OFS_NEXT_EVT:  s_d.next_evt         = writedata;
				// Table is frozen while a routine runs
				`OFS_SR_TIME: begin
					if (s_q.st == ST_IDLE && s_q.sr_sel < 5'(`SR_MAX))
						s_d.sr_tab[s_q.sr_sel] = writedata;
				end
				default: ;
			endcase
		end

		// Count above the list size is clamped; zero leaves no stops
		sr_eff = (s_q.run.cfg.sr_count > 5'(`SR_MAX)) ? 5'(`SR_MAX)
		                                               : s_q.run.cfg.sr_count;
		sr_hit = s_q.run.cfg.sr_en && s_q.sr_idx < sr_eff
		         && s_q.rtc == s_q.sr_tab[s_q.sr_idx];
		bt     = s_q.run.cfg.count_per_vessel_basis && !s_q.run.cfg.storm;
		stt    = s_q.run.cfg.set_time && !s_q.run.cfg.storm;

		unique case (s_q.st)
			ST_IDLE: begin
				if (start_cmd) begin
					s_d.run = s_q.prog;
					s_d.dly = 32'h0000_0000;
					s_d.st  = ST_DELAY;
				end
			end
			ST_DELAY: begin
				// Enable level only looked at once the delay has run out
				if (tick) s_d.dly = s_q.dly + 32'h0000_0001;
				if (s_q.run.cfg.st_valid ? (s_q.rtc >= s_q.run.start_time)
				                         : (s_q.dly >= s_q.run.start_delay)) begin
					if (en) begin
						go_run = 1'b1;
						smp    = s_q.run.cfg.flow ? s_q.run.cfg.flow_start : 1'b1;
					end else begin
						s_d.st = ST_WAIT_EN;
					end
				end
			end
			ST_WAIT_EN, ST_SUSP: begin
				if (s_q.run.cfg.nonuni_clock && s_q.armed && s_q.rtc >= s_q.next_evt) begin
					s_d.missed = 1'b1;
					s_d.armed  = 1'b0;
				end
				if (en) begin
					go_run = (s_q.st == ST_WAIT_EN);
					s_d.st = ST_RUN;
					s_d.pace_cnt = 32'h0000_0000;
					if (s_q.run.cfg.flow)
						smp = s_q.run.cfg.smp_enable;
					else if (s_q.run.cfg.nonuni_clock && s_q.st == ST_SUSP)
						smp = s_q.missed || s_d.missed;
					else
						smp = 1'b1;
					// Cleared only after an event missed in this very cycle is counted
					s_d.missed   = 1'b0;
				end
			end
			ST_RUN: begin
				if (!en) begin
					s_d.st = ST_SUSP;
				end else if (sr_hit) begin
					s_d.sr_idx = s_q.sr_idx + 5'h01;
					if (!s_q.sr_idx[0]) begin
						s_d.st = ST_PAUSE;
						smp    = s_q.run.cfg.smp_stop;
					end
				end else if (s_q.run.cfg.nonuni_clock && !s_q.run.cfg.flow) begin
					if (s_q.armed && s_q.rtc >= s_q.next_evt) begin
						smp       = 1'b1;
						s_d.armed = 1'b0;
					end
				end else if (s_q.run.cfg.flow ? flow_edge : tick) begin
					if (reached(s_q.pace_cnt, s_q.run.pace)) begin
						smp          = 1'b1;
						s_d.pace_cnt = 32'h0000_0000;
					end else begin
						s_d.pace_cnt = s_q.pace_cnt + 32'h0000_0001;
					end
				end
			end
			ST_PAUSE: begin
				if (sr_hit) begin
					s_d.sr_idx   = s_q.sr_idx + 5'h01;
					s_d.st       = ST_RUN;
					s_d.pace_cnt = 32'h0000_0000;
					smp          = s_q.run.cfg.smp_resume;
				end
			end
		endcase

		// Manual request only honoured while idle, running or paused
		if (man_cmd && !s_q.run.cfg.storm
		    && (s_q.st == ST_IDLE || s_q.st == ST_RUN || s_q.st == ST_PAUSE)
		    && !(s_q.st == ST_RUN && !en))
			smp = 1'b1;

		if (go_run) begin
			s_d.st         = ST_RUN;
			s_d.pace_cnt   = 32'h0000_0000;
			s_d.bot_tmr    = 32'h0000_0000;
			s_d.set_tmr    = 32'h0000_0000;
			s_d.bot_smp    = 32'h0000_0000;
			s_d.set_smp    = 32'h0000_0000;
			s_d.sr_idx     = 5'h00;
			s_d.first_done = 1'b0;
		end

		active = s_q.st == ST_RUN || s_q.st == ST_PAUSE || s_q.st == ST_SUSP;
		if (active) begin
			if (s_q.run.cfg.fs_valid && !s_q.first_done && (bt || stt)) begin
				if (s_q.rtc == s_q.run.first_sw) begin
					s_d.first_done = 1'b1;
					s_d.adv_bot    = bt;
					s_d.adv_set    = stt;
				end
			end else if (tick) begin
				if (bt) begin
					s_d.bot_tmr = reached(s_q.bot_tmr, s_q.run.bot_time_iv)
					              ? 32'h0000_0000 : s_q.bot_tmr + 32'h0000_0001;
					s_d.adv_bot = reached(s_q.bot_tmr, s_q.run.bot_time_iv);
				end
				if (stt) begin
					s_d.set_tmr = reached(s_q.set_tmr, s_q.run.set_time_iv)
					              ? 32'h0000_0000 : s_q.set_tmr + 32'h0000_0001;
					s_d.adv_set = reached(s_q.set_tmr, s_q.run.set_time_iv);
				end
			end
		end
		if ((active || go_run) && smp) begin
			// Next value, so a start sample counts from the zeroed counter
			if (!bt) begin
				s_d.adv_bot = reached(s_d.bot_smp, s_q.run.bot_cnt);
				s_d.bot_smp = s_d.adv_bot ? 32'h0000_0000 : s_d.bot_smp + 32'h0000_0001;
			end
			if (!stt) begin
				s_d.adv_set = reached(s_d.set_smp, s_q.run.set_cnt);
				s_d.set_smp = s_d.adv_set ? 32'h0000_0000 : s_d.set_smp + 32'h0000_0001;
			end
		end

		// Software arming wins over consumption in the same cycle
		if (wr && address == `OFS_NEXT_EVT) s_d.armed = 1'b1;
		s_d.sample = smp;
		if (abort_cmd) s_d.st = ST_IDLE;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q        <= '0;
			s_q.st     <= ST_IDLE;
			s_q.wait_q <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign readdata       = s_q.rdata;
	assign waitrequest    = s_q.wait_q;
	assign sample_event   = s_q.sample;
	assign advance_bottle = s_q.adv_bot;
	assign advance_set    = s_q.adv_set;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_start_from_delay;
		$past(s_q.st) == ST_DELAY && s_q.st == ST_RUN;
	endsequence

	sequence s_leave_susp;
		$past(s_q.st) == ST_SUSP && s_q.st == ST_RUN;
	endsequence

	property p_time_start_sample;
		(s_start_from_delay and !s_q.run.cfg.flow) |-> sample_event;
	endproperty
	a_time_start_sample: assert property (p_time_start_sample)
		else $error("time-paced start without sample");

	property p_flow_start_sample;
		s_start_from_delay |-> (!s_q.run.cfg.flow || sample_event == s_q.run.cfg.flow_start);
	endproperty
	a_flow_start_sample: assert property (p_flow_start_sample)
		else $error("flow start sample disagrees with setting");

	property p_delay_ignores_disable;
		s_q.st == ST_DELAY |=> s_q.st != ST_SUSP;
	endproperty
	a_delay_ignores_disable: assert property (p_delay_ignores_disable)
		else $error("disabled during delay to start");

	property p_disable_suspends;
		(s_q.st == ST_RUN && !s_q.en2 && !write) |=> s_q.st == ST_SUSP;
	endproperty
	a_disable_suspends: assert property (p_disable_suspends)
		else $error("run did not suspend on disable");

	property p_no_sample_when_held;
		(s_q.st == ST_SUSP || s_q.st == ST_DELAY || s_q.st == ST_WAIT_EN)
			##1 (s_q.st == $past(s_q.st)) |-> !sample_event;
	endproperty
	a_no_sample_when_held: assert property (p_no_sample_when_held)
		else $error("sample while held off");

	property p_reenable_time_sample;
		(s_leave_susp and !s_q.run.cfg.flow && !s_q.run.cfg.nonuni_clock) |-> sample_event;
	endproperty
	a_reenable_time_sample: assert property (p_reenable_time_sample)
		else $error("no sample on re-enable");

	property p_stop_sample;
		($past(s_q.st) == ST_RUN && s_q.st == ST_PAUSE)
			|-> sample_event == s_q.run.cfg.smp_stop;
	endproperty
	a_stop_sample: assert property (p_stop_sample)
		else $error("stop sample disagrees with setting");

	property p_resume_sample;
		($past(s_q.st) == ST_PAUSE && s_q.st == ST_RUN)
			|-> sample_event == s_q.run.cfg.smp_resume;
	endproperty
	a_resume_sample: assert property (p_resume_sample)
		else $error("resume sample disagrees with setting");

	property p_settings_held;
		(s_q.st != ST_IDLE && $past(s_q.st) != ST_IDLE) |-> s_q.run == $past(s_q.run);
	endproperty
	a_settings_held: assert property (p_settings_held)
		else $error("settings changed during routine");

endmodule : sampling_routine_sequencer

// file: logic/sampler_consts.svh
`ifndef SAMPLER_CONSTS_SVH
`define SAMPLER_CONSTS_SVH

`define CLK_FREQ_KHZ   100_000
`define TICK_PERIOD_MS 1000
`define TICK_CYCLES    (`TICK_PERIOD_MS * `CLK_FREQ_KHZ)

`define SR_MAX 24
`define CFG_W  17

`define OFS_CTRL      8'h00
`define OFS_CFG       8'h04
`define OFS_START_T   8'h08
`define OFS_START_DLY 8'h0C
`define OFS_PACE      8'h10
`define OFS_BOT_TIME  8'h14
`define OFS_SET_TIME  8'h18
`define OFS_BOT_CNT   8'h1C
`define OFS_SET_CNT   8'h20
`define OFS_FIRST_SW  8'h24
`define OFS_RTC       8'h28
`define OFS_STATUS    8'h2C
`define OFS_SR_SEL    8'h30
`define OFS_SR_TIME   8'h34
`define OFS_NEXT_EVT  8'h38

`define CTRL_START  0
`define CTRL_ABORT  1
`define CTRL_MANUAL 2

`endif

// file: logic/sampler_pkg.sv
package sampler_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DELAY,
		ST_WAIT_EN,
		ST_RUN,
		ST_PAUSE,
		ST_SUSP
	} seq_state_t;

	// Bit 0 upward in declaration order from the bottom
	typedef struct packed {
		logic [4:0] sr_count;
		logic       storm;
		logic       nonuni_clock;
		logic       smp_enable;
		logic       flow_start;
		logic       smp_resume;
		logic       smp_stop;
		logic       sr_en;
		logic       fs_valid;
		logic       st_valid;
		logic       set_time;
		logic       count_per_vessel_basis;
		logic       flow;
	} cfg_t;

	typedef struct packed {
		cfg_t        cfg;
		logic [31:0] start_time;
		logic [31:0] start_delay;
		logic [31:0] pace;
		logic [31:0] bot_time_iv;
		logic [31:0] set_time_iv;
		logic [31:0] bot_cnt;
		logic [31:0] set_cnt;
		logic [31:0] first_sw;
	} prog_t;

endpackage : sampler_pkg

// file: verification/flow_meter_model.sv
module flow_meter_model (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       enable_level,
	input  wire logic       go,
	input  wire logic [3:0] burst,
	output logic            flow_pulse,
	output logic            flow_enable
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] left_q;
	logic [2:0] phase_q;

	// Level is held by the meter for as long as its condition lasts
	assign flow_enable = enable_level;

	// Three cycles high, three low: wide enough for the 2FF sync
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			left_q     <= 4'h0;
			phase_q    <= 3'h0;
			flow_pulse <= 1'b0;
		end else if (go) begin
			left_q  <= burst;
			phase_q <= 3'h0;
		end else if (left_q != 4'h0) begin
			phase_q    <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
			flow_pulse <= (phase_q < 3'h3);
			if (phase_q == 3'h5) begin
				left_q <= left_q - 4'h1;
			end
		end else begin
			flow_pulse <= 1'b0;
		end
	end
endmodule : flow_meter_model

// file: verification/sampling_routine_sequencer_tb.sv
`include "sampler_consts.svh"

module sampling_routine_sequencer_tb
	import sampler_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock;
	logic        rst_n;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        flow_pulse;
	logic        flow_enable;
	logic        sample_event;
	logic        advance_bottle;
	logic        advance_set;
	logic        en_level;
	logic        go;
	logic [3:0]  burst;
	logic [31:0] q;
	cfg_t        c;
	int          bad_count;
	int          cmp_count;
	int          smp_cnt;
	int          bot_cnt;
	int          s0;
	int          b0;
	int          set_cnt;
	int          t0;

	sampling_routine_sequencer #(.TICK_CYCLES(10)) u_sampling_routine_sequencer (
		.clock          (clock),
		.rst_n          (rst_n),
		.address        (address),
		.read           (read),
		.write          (write),
		.writedata      (writedata),
		.readdata       (readdata),
		.waitrequest    (waitrequest),
		.flow_pulse     (flow_pulse),
		.flow_enable    (flow_enable),
		.sample_event   (sample_event),
		.advance_bottle (advance_bottle),
		.advance_set    (advance_set)
	);

	flow_meter_model u_flow_meter_model (
		.clock        (clock),
		.rst_n        (rst_n),
		.enable_level (en_level),
		.go           (go),
		.burst        (burst),
		.flow_pulse   (flow_pulse),
		.flow_enable  (flow_enable)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Pulses stand one cycle, so the falling edge sees each once
	always @(negedge clock) begin
		if (sample_event === 1'b1) smp_cnt++;
		if (advance_bottle === 1'b1) bot_cnt++;
		if (advance_set === 1'b1) set_cnt++;
	end

	task automatic end_sim;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		address   <= a;
		writedata <= d;
		write     <= is_wr;
		read      <= !is_wr;
		// Answer is judged at the rising edge, where it has settled
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (waitrequest === 1'b0) break;
		end
		if (n == 50) begin
			bad_count++;
			end_sim();
		end else begin
			q     = readdata;
			read  <= 1'b0;
			write <= 1'b0;
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Polls the state field under a bounded count
	task automatic wait_state(input logic [2:0] st);
		for (int n = 0; n < 60; n++) begin
			rd(`OFS_STATUS);
			if (q[2:0] === st) break;
		end
		chk("state", {29'h0, st}, {29'h0, q[2:0]});
	endtask : wait_state

	task automatic start_run(input cfg_t cc, input logic [31:0] d, input logic [31:0] p,
			input logic en);
		wr(`OFS_CTRL, 32'h0000_0002);
		en_level <= en;
		wr(`OFS_CFG, 32'(cc));
		wr(`OFS_START_DLY, d);
		wr(`OFS_PACE, p);
		s0 = smp_cnt;
		b0 = bot_cnt;
		t0 = set_cnt;
		wr(`OFS_CTRL, 32'h0000_0001);
	endtask : start_run

	initial begin
		rst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0000_0000;
		en_level = 1'b1;
		go = 1'b0;
		burst = 4'h0;
		bad_count = 0;
		cmp_count = 0;
		smp_cnt = 0;
		bot_cnt = 0;
		set_cnt = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rd(`OFS_STATUS);
		chk("status", 32'h0000_0000, q);
		rd(`OFS_CFG);
		chk("cfg", 32'h0000_0000, q);
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C);
		chk("unmapped", 32'h0000_0000, q);
		wr(`OFS_CFG, 32'h0000_0FFF);
		rd(`OFS_CFG);
		chk("cfg", 32'h0000_0FFF, q);
		// Time-paced, no delay, enabled at start
		c = '0;
		start_run(c, 32'h0000_0000, 32'h0000_0064, 1'b1);
		repeat (4) @(posedge clock);
		chk("samples", 1, 32'(smp_cnt - s0));
		wait_state(ST_RUN);
		wr(`OFS_CTRL, 32'h0000_0004);
		repeat (3) @(posedge clock);
		chk("samples", 2, 32'(smp_cnt - s0));
		en_level <= 1'b0;
		repeat (8) @(posedge clock);
		wait_state(ST_SUSP);
		wr(`OFS_CTRL, 32'h0000_0004);
		repeat (3) @(posedge clock);
		chk("samples", 2, 32'(smp_cnt - s0));
		en_level <= 1'b1;
		wait_state(ST_RUN);
		// Disabled through the delay: time, flow, flow with enable sample
		for (int m = 0; m < 3; m++) begin
			c = '0;
			c.flow = (m != 0);
			c.smp_enable = (m == 2);
			start_run(c, 32'h0000_0003, 32'h0000_0064, 1'b0);
			repeat (12) @(posedge clock);
			rd(`OFS_STATUS);
			chk("state", {29'h0, ST_DELAY}, {29'h0, q[2:0]});
			wr(`OFS_CTRL, 32'h0000_0004);
			wait_state(ST_WAIT_EN);
			chk("samples", 0, 32'(smp_cnt - s0));
			en_level <= 1'b1;
			wait_state(ST_RUN);
			repeat (3) @(posedge clock);
			chk("samples", (m != 1), 32'(smp_cnt - s0));
		end
		// Start time wins over a long delay
		wr(`OFS_RTC, 32'h0000_0000);
		wr(`OFS_START_T, 32'h0000_0004);
		c = '0;
		c.st_valid = 1'b1;
		start_run(c, 32'h0000_00C8, 32'h0000_0064, 1'b1);
		wait_state(ST_RUN);
		repeat (3) @(posedge clock);
		chk("samples", 1, 32'(smp_cnt - s0));
		// Flow pacing with count-based bottle change
		wr(`OFS_BOT_CNT, 32'h0000_0002);
		for (int fs = 0; fs < 2; fs++) begin
			c = '0;
			c.flow = 1'b1;
			c.flow_start = fs[0];
			start_run(c, 32'h0000_0000, 32'h0000_0002, 1'b1);
			repeat (6) @(posedge clock);
			chk("samples", fs, 32'(smp_cnt - s0));
			go <= 1'b1;
			burst <= 4'h4;
			@(posedge clock);
			go <= 1'b0;
			repeat (50) @(posedge clock);
			chk("samples", fs + 2, 32'(smp_cnt - s0));
			chk("bottles", 1, 32'(bot_cnt - b0));
		end
		// First switch time only under time basis; storm forces count basis
		for (int k = 0; k < 3; k++) begin
			wr(`OFS_RTC, 32'h0000_0000);
			wr(`OFS_FIRST_SW, 32'h0000_0006);
			wr(`OFS_BOT_TIME, 32'h0000_00C8);
			c = '0;
			c.count_per_vessel_basis = (k != 1);
			c.fs_valid = 1'b1;
			c.storm = (k == 2);
			start_run(c, 32'h0000_0000, 32'h0000_00C8, 1'b1);
			repeat (80) @(posedge clock);
			chk("bottles", (k == 0), 32'(bot_cnt - b0));
		end
		// Stop at second 6, resume at 8; sample at stop only
		wr(`OFS_CTRL, 32'h0000_0002);
		wr(`OFS_SR_SEL, 32'h0000_0000);
		wr(`OFS_SR_TIME, 32'h0000_0006);
		wr(`OFS_SR_SEL, 32'h0000_0001);
		wr(`OFS_SR_TIME, 32'h0000_0008);
		wr(`OFS_SET_CNT, 32'h0000_0002);
		wr(`OFS_RTC, 32'h0000_0000);
		c = '0;
		c.sr_en = 1'b1;
		c.smp_stop = 1'b1;
		c.sr_count = 5'h02;
		start_run(c, 32'h0000_0000, 32'h0000_00C8, 1'b1);
		wait_state(ST_PAUSE);
		chk("samples", 2, 32'(smp_cnt - s0));
		wait_state(ST_RUN);
		repeat (3) @(posedge clock);
		chk("samples", 2, 32'(smp_cnt - s0));
		chk("sr_index", 2, {27'h000_0000, q[11:7]});
		chk("bottles", 1, 32'(bot_cnt - b0));
		chk("sets", 1, 32'(set_cnt - t0));
		// Nonuniform clock: the event time passes while disabled
		wr(`OFS_RTC, 32'h0000_0000);
		c = '0;
		c.nonuni_clock = 1'b1;
		start_run(c, 32'h0000_0000, 32'h0000_00C8, 1'b1);
		en_level <= 1'b0;
		wait_state(ST_SUSP);
		wr(`OFS_NEXT_EVT, 32'h0000_0001);
		repeat (4) @(posedge clock);
		en_level <= 1'b1;
		wait_state(ST_RUN);
		repeat (3) @(posedge clock);
		chk("samples", 2, 32'(smp_cnt - s0));
		end_sim();
	end
endmodule : sampling_routine_sequencer_tb
